// [rtl/mpgpio_top.sv]
// GPIO control for ports A..G: AXI4-Lite register file and per-port pad logic.
// Assumes one clock aclk, synchronous active-low reset, pins asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_defs.svh"

module mpgpio_top #(
	parameter int                              NPORT    = `MPGPIO_NPORT,
	parameter int                              ADDR_W   = 12,
	parameter logic [`MPGPIO_NPORT-1:0][31:0]  PIN_MASK = `MPGPIO_PIN_MASK,
	parameter logic [`MPGPIO_NPORT-1:0][31:0]  FR1_MASK = `MPGPIO_FR1_MASK,
	parameter logic [`MPGPIO_NPORT-1:0][31:0]  FR2_MASK = `MPGPIO_FR2_MASK
) (
	// Clock and reset
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	// AXI4-Lite write address
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [ADDR_W-1:0]             s_axi_awaddr,
	input  wire logic [2:0]                    s_axi_awprot,
	// AXI4-Lite write data
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	// AXI4-Lite write response
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	output logic [1:0]                         s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	input  wire logic [ADDR_W-1:0]             s_axi_araddr,
	input  wire logic [2:0]                    s_axi_arprot,
	// AXI4-Lite read data
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic [31:0]                        s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	// Pins, one word per port
	input  wire logic [`MPGPIO_NPORT-1:0][31:0] pad_in,
	output logic      [`MPGPIO_NPORT-1:0][31:0] pad_out,
	output logic      [`MPGPIO_NPORT-1:0][31:0] pad_oe_n,
	output logic      [`MPGPIO_NPORT-1:0][31:0] pad_pu_en,
	output logic      [`MPGPIO_NPORT-1:0][31:0] pad_pd_en,
	// Peripheral function signals
	input  wire logic [`MPGPIO_NPORT-1:0][31:0] fn1_out,
	input  wire logic [`MPGPIO_NPORT-1:0][31:0] fn1_oe,
	input  wire logic [`MPGPIO_NPORT-1:0][31:0] fn2_out,
	input  wire logic [`MPGPIO_NPORT-1:0][31:0] fn2_oe,
	output logic      [`MPGPIO_NPORT-1:0][31:0] fn_in
);
	// Register storage, one word per port per register
	logic [`MPGPIO_NPORT-1:0][31:0] data_q;
	logic [`MPGPIO_NPORT-1:0][31:0] cr_q;
	logic [`MPGPIO_NPORT-1:0][31:0] fr1_q;
	logic [`MPGPIO_NPORT-1:0][31:0] fr2_q;
	logic [`MPGPIO_NPORT-1:0][31:0] od_q;
	logic [`MPGPIO_NPORT-1:0][31:0] pup_q;
	logic [`MPGPIO_NPORT-1:0][31:0] pdn_q;
	logic [`MPGPIO_NPORT-1:0][31:0] ie_q;
	logic [`MPGPIO_NPORT-1:0][31:0] din_w;

	// Write channel state
	logic                           aw_held_q;
	logic [ADDR_W-1:0]              aw_addr_q;
	logic                           w_held_q;
	logic [31:0]                    w_data_q;
	logic [3:0]                     w_strb_q;
	logic                           bvalid_q;
	logic [1:0]                     bresp_q;
	logic                           do_wr;

	// Read channel state
	logic                           rvalid_q;
	logic [31:0]                    rdata_q;
	logic [1:0]                     rresp_q;
	logic                           do_rd;

	// Decoded write and read targets
	mpgpio_pkg::mpgpio_sel_t        wsel;
	logic [2:0]                     wport;
	mpgpio_pkg::mpgpio_sel_t        rsel;
	logic [2:0]                     rport;

	// Register select from the offset field; port range checked separately
	function automatic mpgpio_pkg::mpgpio_sel_t dec_sel(input logic [ADDR_W-1:0] a);
		logic [5:0] off;
		off = a[`MPGPIO_OFF_MSB:`MPGPIO_OFF_LSB];
		if (int'(a[`MPGPIO_PORT_MSB:`MPGPIO_PORT_LSB]) >= NPORT
			|| a[ADDR_W-1:`MPGPIO_PORT_MSB+1] != '0)
			return mpgpio_pkg::MPGPIO_SEL_NONE;
		case (off)
			`MPGPIO_OFF_DATA: return mpgpio_pkg::MPGPIO_SEL_DATA;
			`MPGPIO_OFF_CR:   return mpgpio_pkg::MPGPIO_SEL_CR;
			`MPGPIO_OFF_FR1:  return mpgpio_pkg::MPGPIO_SEL_FR1;
			`MPGPIO_OFF_FR2:  return mpgpio_pkg::MPGPIO_SEL_FR2;
			`MPGPIO_OFF_OD:   return mpgpio_pkg::MPGPIO_SEL_OD;
			`MPGPIO_OFF_PUP:  return mpgpio_pkg::MPGPIO_SEL_PUP;
			`MPGPIO_OFF_PDN:  return mpgpio_pkg::MPGPIO_SEL_PDN;
			`MPGPIO_OFF_IE:   return mpgpio_pkg::MPGPIO_SEL_IE;
			default:          return mpgpio_pkg::MPGPIO_SEL_NONE;
		endcase
	endfunction

	// Byte-lane merge; bits outside the mask stay zero
	function automatic logic [31:0] merge(
		input logic [31:0] old,
		input logic [31:0] nw,
		input logic [3:0]  strb,
		input logic [31:0] mask
	);
		logic [31:0] lanes;
		lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		return ((old & ~lanes) | (nw & lanes)) & mask;
	endfunction

	// Write decode uses the held address, read decode the live one
	assign wsel  = dec_sel(aw_addr_q);
	assign wport = aw_addr_q[`MPGPIO_PORT_MSB:`MPGPIO_PORT_LSB];
	assign rsel  = dec_sel(s_axi_araddr);
	assign rport = s_axi_araddr[`MPGPIO_PORT_MSB:`MPGPIO_PORT_LSB];

	// Handshake outputs; one write and one read in flight at a time
	assign s_axi_awready = !aw_held_q && !bvalid_q;
	assign s_axi_wready  = !w_held_q && !bvalid_q;
	assign s_axi_bvalid  = bvalid_q;
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign do_wr         = aw_held_q && w_held_q && !bvalid_q;
	assign do_rd         = s_axi_arvalid && !rvalid_q;

	// Address and data are caught separately, in either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held_q <= 1'b0;
			aw_addr_q <= '0;
			w_held_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			else if (do_wr)
				aw_held_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			else if (do_wr)
				w_held_q <= 1'b0;
		end
	end

	// Write response; unmapped offsets answer SLVERR and store nothing
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= `MPGPIO_RESP_OKAY;
		end
		else if (do_wr)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= (wsel == mpgpio_pkg::MPGPIO_SEL_NONE) ?
				`MPGPIO_RESP_SLVERR : `MPGPIO_RESP_OKAY;
		end
		else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	// Output values and drive enables; reset leaves every pin undriven but port B pin 2
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			data_q <= '0;
			cr_q   <= `MPGPIO_RST_CR;
		end
		else if (do_wr)
		begin
			if (wsel == mpgpio_pkg::MPGPIO_SEL_DATA)
				data_q[wport] <= merge(data_q[wport], w_data_q, w_strb_q,
					PIN_MASK[wport]);
			if (wsel == mpgpio_pkg::MPGPIO_SEL_CR)
				cr_q[wport] <= merge(cr_q[wport], w_data_q, w_strb_q,
					PIN_MASK[wport]);
		end
	end

	// Function selects; ports without a function register keep zero
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			fr1_q <= '0;
			fr2_q <= `MPGPIO_RST_FR2;
		end
		else if (do_wr)
		begin
			if (wsel == mpgpio_pkg::MPGPIO_SEL_FR1)
				fr1_q[wport] <= merge(fr1_q[wport], w_data_q, w_strb_q,
					FR1_MASK[wport]);
			if (wsel == mpgpio_pkg::MPGPIO_SEL_FR2)
				fr2_q[wport] <= merge(fr2_q[wport], w_data_q, w_strb_q,
					FR2_MASK[wport]);
		end
	end

	// Open-drain and pull settings
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			od_q  <= '0;
			pup_q <= `MPGPIO_RST_PUP;
			pdn_q <= `MPGPIO_RST_PDN;
		end
		else if (do_wr)
		begin
			if (wsel == mpgpio_pkg::MPGPIO_SEL_OD)
				od_q[wport] <= merge(od_q[wport], w_data_q, w_strb_q,
					PIN_MASK[wport]);
			if (wsel == mpgpio_pkg::MPGPIO_SEL_PUP)
				pup_q[wport] <= merge(pup_q[wport], w_data_q, w_strb_q,
					PIN_MASK[wport]);
			if (wsel == mpgpio_pkg::MPGPIO_SEL_PDN)
				pdn_q[wport] <= merge(pdn_q[wport], w_data_q, w_strb_q,
					PIN_MASK[wport]);
		end
	end

	// Input enables; inputs other than port B pins 1 and 2 start gated off to keep floating pins quiet
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ie_q <= `MPGPIO_RST_IE;
		else if (do_wr && wsel == mpgpio_pkg::MPGPIO_SEL_IE)
			ie_q[wport] <= merge(ie_q[wport], w_data_q, w_strb_q,
				PIN_MASK[wport]);
	end

	// Read path; a pin with input enabled shows its synced level
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rresp_q  <= `MPGPIO_RESP_OKAY;
		end
		else if (do_rd)
		begin
			rvalid_q <= 1'b1;
			rresp_q  <= `MPGPIO_RESP_OKAY;
			case (rsel)
				mpgpio_pkg::MPGPIO_SEL_DATA:
					rdata_q <= ((din_w[rport] & ie_q[rport])
						| (data_q[rport] & ~ie_q[rport]))
						& PIN_MASK[rport];
				mpgpio_pkg::MPGPIO_SEL_CR:  rdata_q <= cr_q[rport];
				mpgpio_pkg::MPGPIO_SEL_FR1: rdata_q <= fr1_q[rport];
				mpgpio_pkg::MPGPIO_SEL_FR2: rdata_q <= fr2_q[rport];
				mpgpio_pkg::MPGPIO_SEL_OD:  rdata_q <= od_q[rport];
				mpgpio_pkg::MPGPIO_SEL_PUP: rdata_q <= pup_q[rport];
				mpgpio_pkg::MPGPIO_SEL_PDN: rdata_q <= pdn_q[rport];
				mpgpio_pkg::MPGPIO_SEL_IE:  rdata_q <= ie_q[rport];
				default:
				begin
					rdata_q <= 32'h0000_0000;
					rresp_q <= `MPGPIO_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// One pad block per port, settings carried in an interface
	for (genvar p = 0; p < NPORT; p++)
	begin : g_port
		mpgpio_cfg_if cfg ();

		// Register words out to the pads, synced pin levels back
		assign cfg.dout = data_q[p];
		assign cfg.cr   = cr_q[p];
		assign cfg.fr1  = fr1_q[p];
		assign cfg.fr2  = fr2_q[p];
		assign cfg.od   = od_q[p];
		assign cfg.pup  = pup_q[p];
		assign cfg.pdn  = pdn_q[p];
		assign cfg.ie   = ie_q[p];
		assign din_w[p] = cfg.din;

		// Per-port mask keeps missing pins undriven and unpulled
		mpgpio_pad_port #(
			.PIN_MASK (PIN_MASK[p])
		) u_pad (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.cfg       (cfg),
			.pad_in    (pad_in[p]),
			.pad_out   (pad_out[p]),
			.pad_oe_n  (pad_oe_n[p]),
			.pad_pu_en (pad_pu_en[p]),
			.pad_pd_en (pad_pd_en[p]),
			.fn1_out   (fn1_out[p]),
			.fn1_oe    (fn1_oe[p]),
			.fn2_out   (fn2_out[p]),
			.fn2_oe    (fn2_oe[p]),
			.fn_in     (fn_in[p])
		);
	end
endmodule
`default_nettype wire

// [rtl/mpgpio_defs.svh]
// Offsets, field masks and reset values for the GPIO port block.
// Assumes includers use the macros only; no code lives here.
`ifndef MPGPIO_DEFS_SVH
`define MPGPIO_DEFS_SVH

// Register offsets inside one port window
`define MPGPIO_OFF_DATA   6'h00
`define MPGPIO_OFF_CR     6'h04
`define MPGPIO_OFF_FR1    6'h08
`define MPGPIO_OFF_FR2    6'h0c
`define MPGPIO_OFF_OD     6'h28
`define MPGPIO_OFF_PUP    6'h2c
`define MPGPIO_OFF_PDN    6'h30
`define MPGPIO_OFF_IE     6'h38

// Port window stride and field positions in the byte address
`define MPGPIO_PORT_STRIDE 12'h040
`define MPGPIO_OFF_LSB     0
`define MPGPIO_OFF_MSB     5
`define MPGPIO_PORT_LSB    6
`define MPGPIO_PORT_MSB    8

// Number of ports A..G
`define MPGPIO_NPORT 7

// Implemented bits; entries run port G down to port A
`define MPGPIO_PIN_MASK {7{32'h0000_00ff}}
`define MPGPIO_FR1_MASK {{5{32'h0000_00ff}}, 32'h0000_000e, 32'h0000_0000}
`define MPGPIO_FR2_MASK {{5{32'h0000_0000}}, 32'h0000_0006, 32'h0000_0000}

// Reset values; only port B leaves reset with debug pins configured
`define MPGPIO_RST_CR  {{5{32'h0000_0000}}, 32'h0000_0004, 32'h0000_0000}
`define MPGPIO_RST_FR2 {{5{32'h0000_0000}}, 32'h0000_0006, 32'h0000_0000}
`define MPGPIO_RST_PUP {{5{32'h0000_0000}}, 32'h0000_0004, 32'h0000_0000}
`define MPGPIO_RST_PDN {{5{32'h0000_0000}}, 32'h0000_0002, 32'h0000_0000}
`define MPGPIO_RST_IE  {{5{32'h0000_0000}}, 32'h0000_0006, 32'h0000_0000}

// AXI responses
`define MPGPIO_RESP_OKAY   2'b00
`define MPGPIO_RESP_SLVERR 2'b10

`endif

// [rtl/mpgpio_pkg.sv]
// Types shared by the GPIO port block.
// Assumes mpgpio_defs.svh supplies the numbers.
package mpgpio_pkg;
	typedef logic [31:0] mpgpio_word_t;
	typedef enum {
		MPGPIO_SEL_DATA, MPGPIO_SEL_CR, MPGPIO_SEL_FR1, MPGPIO_SEL_FR2,
		MPGPIO_SEL_OD, MPGPIO_SEL_PUP, MPGPIO_SEL_PDN, MPGPIO_SEL_IE,
		MPGPIO_SEL_NONE
	} mpgpio_sel_t;
endpackage

// [rtl/mpgpio_cfg_if.sv]
// Per-port settings from the register file to the pad logic, and pin levels back.
// Assumes one instance per port, driven by the top on one clock.
`timescale 1ns/1ps
`default_nettype none
interface mpgpio_cfg_if;
	mpgpio_pkg::mpgpio_word_t dout;
	mpgpio_pkg::mpgpio_word_t cr;
	mpgpio_pkg::mpgpio_word_t fr1;
	mpgpio_pkg::mpgpio_word_t fr2;
	mpgpio_pkg::mpgpio_word_t od;
	mpgpio_pkg::mpgpio_word_t pup;
	mpgpio_pkg::mpgpio_word_t pdn;
	mpgpio_pkg::mpgpio_word_t ie;
	mpgpio_pkg::mpgpio_word_t din;

	modport regs (output dout, cr, fr1, fr2, od, pup, pdn, ie, input din);
	modport pad (input dout, cr, fr1, fr2, od, pup, pdn, ie, output din);
endinterface
`default_nettype wire

// [rtl/mpgpio_pad_port.sv]
// Pad logic of one port: input sync and gating, output mux, drive and pulls.
// Assumes pad_in comes from pins asynchronously; peripherals share aclk.
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_defs.svh"
module mpgpio_pad_port #(
	parameter logic [31:0] PIN_MASK = 32'h0000_00ff
) (
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// Settings from the register file
	mpgpio_cfg_if.pad        cfg,
	// Pins
	input  wire logic [31:0] pad_in,
	output logic      [31:0] pad_out,
	output logic      [31:0] pad_oe_n,
	output logic      [31:0] pad_pu_en,
	output logic      [31:0] pad_pd_en,
	// Peripheral functions
	input  wire logic [31:0] fn1_out,
	input  wire logic [31:0] fn1_oe,
	input  wire logic [31:0] fn2_out,
	input  wire logic [31:0] fn2_oe,
	output logic      [31:0] fn_in
);
	logic [31:0] s1_q;
	logic [31:0] s2_q;
	logic [31:0] s3_q;
	logic [31:0] lvl_q;
	logic [31:0] out_d;
	logic [31:0] drv_d;
	logic [31:0] fsel;

	// Three-stage sync; a level counts once stages two and three agree
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s1_q  <= 32'h0000_0000;
			s2_q  <= 32'h0000_0000;
			s3_q  <= 32'h0000_0000;
			lvl_q <= 32'h0000_0000;
		end
		else
		begin
			s1_q  <= pad_in;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (lvl_q & ~(s2_q ~^ s3_q)) | (s2_q & (s2_q ~^ s3_q));
		end
	end

	// Input gate after the sync; a disabled input reads low, and enabling it needs no settle delay
	assign cfg.din = lvl_q & cfg.ie & PIN_MASK;

	// Function 2 wins over function 1 if software breaks exclusivity
	always_comb
	begin
		fsel  = cfg.fr1 | cfg.fr2;
		out_d = (cfg.fr2 & fn2_out) | (~cfg.fr2 & cfg.fr1 & fn1_out)
			| (~fsel & cfg.dout);
		drv_d = cfg.cr & ((cfg.fr2 & fn2_oe) | (~cfg.fr2 & cfg.fr1 & fn1_oe) | ~fsel);
		drv_d = drv_d & ~(cfg.od & out_d) & PIN_MASK;
	end

	// Registered pad drive and function inputs
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pad_out   <= 32'h0000_0000;
			pad_oe_n  <= 32'hffff_ffff;
			pad_pu_en <= 32'h0000_0000;
			pad_pd_en <= 32'h0000_0000;
			fn_in     <= 32'h0000_0000;
		end
		else
		begin
			pad_out   <= out_d & PIN_MASK;
			pad_oe_n  <= ~drv_d;
			pad_pu_en <= cfg.pup & PIN_MASK;
			pad_pd_en <= cfg.pdn & PIN_MASK;
			fn_in     <= lvl_q & cfg.ie & fsel & PIN_MASK;
		end
	end
endmodule
`default_nettype wire

// [testbench/mpgpio_monitor.sv]
// Checker for the GPIO port block: bus handshakes and unused pin bits.
// Assumes it is bound to mpgpio_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_defs.svh"
module mpgpio_monitor (
	// Clock and reset
	input wire logic                             aclk,
	input wire logic                             aresetn,
	// Register bus
	input wire logic                             s_axi_awvalid,
	input wire logic                             s_axi_awready,
	input wire logic                             s_axi_wvalid,
	input wire logic                             s_axi_wready,
	input wire logic                             s_axi_bvalid,
	input wire logic                             s_axi_bready,
	input wire logic [1:0]                       s_axi_bresp,
	input wire logic                             s_axi_arvalid,
	input wire logic                             s_axi_arready,
	input wire logic                             s_axi_rvalid,
	input wire logic                             s_axi_rready,
	input wire logic [31:0]                      s_axi_rdata,
	input wire logic [1:0]                       s_axi_rresp,
	// Pins
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_oe_n,
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_pu_en,
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_pd_en
);
	// Only eight pins per port exist, so upper bits must stay idle
	localparam logic [`MPGPIO_NPORT-1:0][31:0] PINS = `MPGPIO_PIN_MASK;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// Handshake steps used by the latency checks
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	property p_wr_answer;   s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
	property p_rd_answer;   s_rd_taken |=> s_axi_rvalid; endproperty
	property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rvalid_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endproperty
	property p_wr_block;    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rd_block;    s_axi_rvalid |-> !s_axi_arready; endproperty
	property p_rd_unused;   s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000; endproperty
	property p_err_zero;    s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rdata == 32'h0; endproperty
	property p_bresp_code;  s_axi_bvalid |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2; endproperty
	property p_pull_unused; ((pad_pu_en | pad_pd_en) & ~PINS) == '0; endproperty
	property p_drive_unused; (~pad_oe_n & ~PINS) == '0; endproperty

	a_wr_answer:    assert property (p_wr_answer) else $error("write answer late");
	a_rd_answer:    assert property (p_rd_answer) else $error("read answer late");
	a_bvalid_hold:  assert property (p_bvalid_hold) else $error("write response dropped");
	a_rvalid_hold:  assert property (p_rvalid_hold) else $error("read data dropped");
	a_wr_block:     assert property (p_wr_block) else $error("write taken while busy");
	a_rd_block:     assert property (p_rd_block) else $error("read taken while busy");
	a_rd_unused:    assert property (p_rd_unused) else $error("unused bits read nonzero");
	a_err_zero:     assert property (p_err_zero) else $error("error read carries data");
	a_bresp_code:   assert property (p_bresp_code) else $error("bad write response");
	a_pull_unused:  assert property (p_pull_unused) else $error("pull on missing pin");
	a_drive_unused: assert property (p_drive_unused) else $error("drive on missing pin");
endmodule
bind mpgpio_top mpgpio_monitor u_mpgpio_monitor (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pad_oe_n,
	.pad_pu_en, .pad_pd_en);
`default_nettype wire

// [testbench/mpgpio_pin_model.sv]
// Pins and peripherals around the GPIO block: resolves each pin level.
// Assumes one outside level and drive mask shared by all ports.
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_defs.svh"
module mpgpio_pin_model (
	// Clock
	input wire logic                             aclk,
	// Device pin side
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_out,
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_oe_n,
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_pu_en,
	input wire logic [`MPGPIO_NPORT-1:0][31:0]   pad_pd_en,
	output logic     [`MPGPIO_NPORT-1:0][31:0]   pad_in,
	// Outside world and peripheral pattern
	input wire logic [31:0]                      ext_lvl,
	input wire logic [31:0]                      ext_drv,
	input wire logic [31:0]                      fn_pat,
	output logic     [`MPGPIO_NPORT-1:0][31:0]   fn1_out,
	output logic     [`MPGPIO_NPORT-1:0][31:0]   fn1_oe,
	output logic     [`MPGPIO_NPORT-1:0][31:0]   fn2_out,
	output logic     [`MPGPIO_NPORT-1:0][31:0]   fn2_oe
);
	logic float_q = 1'b0;

	// Floating pins wander so a stale level never passes
	always_ff @(posedge aclk)
		float_q <= ~float_q;

	// Device drive wins, then outside drive, then pulls, else floating
	always_comb
	begin
		for (int p = 0; p < `MPGPIO_NPORT; p++)
			pad_in[p] = (~pad_oe_n[p] & pad_out[p]) | (pad_oe_n[p] & ext_drv & ext_lvl)
				| (pad_oe_n[p] & ~ext_drv & pad_pu_en[p])
				| (pad_oe_n[p] & ~ext_drv & ~pad_pu_en[p] & ~pad_pd_en[p] & {32{float_q}});
	end

	// Peripherals always ask to drive; function 2 shows the inverse pattern
	assign fn1_out = {`MPGPIO_NPORT{fn_pat}};
	assign fn2_out = {`MPGPIO_NPORT{~fn_pat}};
	assign fn1_oe  = '1;
	assign fn2_oe  = '1;
endmodule
`default_nettype wire

// [testbench/tb_mpgpio_top.sv]
// Self-checking bench for the GPIO block over its register bus and pins.
// Assumes mpgpio_monitor is bound in and mpgpio_pin_model stands at the pins.
`timescale 1ns/1ps
`default_nettype none
`include "mpgpio_defs.svh"
module tb_mpgpio_top;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 12'h0, araddr = 12'h0;
	logic [31:0] wdata = 32'h0, rdata, ext_lvl = 32'h0, ext_drv = 32'h0, fn_pat = 32'h1, rv;
	logic [1:0] bresp, rresp, rs;
	logic [`MPGPIO_NPORT-1:0][31:0] pad_in, pad_out, pad_oe_n, pad_pu_en, pad_pd_en, fn_in;
	logic [`MPGPIO_NPORT-1:0][31:0] fn1_out, fn1_oe, fn2_out, fn2_oe;
	int mismatches = 0, check_count = 0;
	logic [5:0] offs [7] = '{6'h04, 6'h0c, 6'h2c, 6'h30, 6'h38, 6'h08, 6'h28};
	logic [31:0] rstv [7] = '{32'h4, 32'h6, 32'h4, 32'h2, 32'h6, 32'h0, 32'h0};

	always #5 aclk = ~aclk;

	mpgpio_top u_mpgpio_top (.aclk, .aresetn, .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_bresp(bresp), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .pad_in, .pad_out, .pad_oe_n, .pad_pu_en,
		.pad_pd_en, .fn1_out, .fn1_oe, .fn2_out, .fn2_oe, .fn_in);
	mpgpio_pin_model u_mpgpio_pin_model (.aclk, .pad_out, .pad_oe_n, .pad_pu_en, .pad_pd_en,
		.pad_in, .ext_lvl, .ext_drv, .fn_pat, .fn1_out, .fn1_oe, .fn2_out, .fn2_oe);

	function automatic logic [11:0] adr(input int p, input logic [5:0] o);
		return 12'(p * 64) | {6'h0, o};
	endfunction
	task automatic ticks(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		bready <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (!aw_done && awready)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		// Response taken at the edge where bvalid meets the held bready
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		// Data taken at the edge where rvalid meets the held rready
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic wchk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		wr(a, d, rs);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		rd(a, rv, rs);
		chk(rv, ed);
		chk({30'h0, rs}, {30'h0, er});
	endtask
	task automatic results();
		$display("compares %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Whole run needs some two hundred cycles; this is well past it
	initial
	begin
		ticks(20000);
		mismatches++;
		results();
	end

	initial
	begin
		ticks(8);
		aresetn <= 1'b1;
		ticks(2);
		// Reset values of port B and its debug pin drive
		for (int i = 0; i < 7; i++) rchk(adr(1, offs[i]), rstv[i], 2'h0);
		chk(pad_pu_en[1], 32'h4);
		chk(pad_pd_en[1], 32'h2);
		chk(pad_out[1] & 32'h6, 32'h6);
		chk(pad_oe_n[1], 32'hffff_fffb);
		$display("reset values done");
		// Only eight bits per register hold; missing registers read zero
		for (int i = 0; i < 7; i++) wchk(adr(2, offs[i]), 32'hdead_bea5, 2'h0);
		for (int i = 0; i < 7; i++) rchk(adr(2, offs[i]), i == 1 ? 32'h0 : 32'ha5, 2'h0);
		wchk(adr(0, 6'h08), 32'hffff_ffff, 2'h0);
		rchk(adr(0, 6'h08), 32'h0, 2'h0);
		wchk(adr(2, 6'h10), 32'h1, 2'h2);
		rchk(adr(7, 6'h00), 32'h0, 2'h2);
		$display("register map done");
		// Port C outputs with open-drain on the low nibble
		wchk(adr(2, 6'h08), 32'h0, 2'h0);
		wchk(adr(2, 6'h28), 32'h0f, 2'h0);
		wchk(adr(2, 6'h04), 32'hff, 2'h0);
		wchk(adr(2, 6'h00), 32'ha5, 2'h0);
		wchk(adr(2, 6'h2c), 32'h30, 2'h0);
		wchk(adr(2, 6'h30), 32'h0c, 2'h0);
		ticks(2);
		chk(pad_out[2], 32'h0000_00a5);
		chk(pad_oe_n[2], 32'hffff_ff05);
		chk(pad_pu_en[2], 32'h30);
		chk(pad_pd_en[2], 32'h0c);
		$display("output drive done");
		// Port D input path, gated then open, then pulled up
		wchk(adr(3, 6'h00), 32'h81, 2'h0);
		ext_drv <= 32'hff;
		ext_lvl <= 32'h3c;
		ticks(8);
		rchk(adr(3, 6'h00), 32'h81, 2'h0);
		wchk(adr(3, 6'h38), 32'hff, 2'h0);
		ticks(8);
		rchk(adr(3, 6'h00), 32'h3c, 2'h0);
		ext_drv <= 32'h0;
		wchk(adr(3, 6'h2c), 32'hff, 2'h0);
		ticks(8);
		rchk(adr(3, 6'h00), 32'hff, 2'h0);
		$display("input path done");
		// Pin 0 of port D handed to function 1, both levels
		wchk(adr(3, 6'h08), 32'h01, 2'h0);
		wchk(adr(3, 6'h04), 32'h01, 2'h0);
		for (int v = 0; v < 2; v++)
		begin
			fn_pat <= 32'(v);
			ticks(8);
			chk({31'h0, pad_out[3][0]}, 32'(v));
			chk({31'h0, pad_oe_n[3][0]}, 32'h0);
			chk({31'h0, fn_in[3][0]}, 32'(v));
		end
		$display("function select done");
		results();
	end
endmodule
`default_nettype wire
